// ---- verilog/cid_defines.vh ----
// constants for the character display instruction decoder
// Functional notes
// - clear fills display with spaces, home, increment
// - clear and home stay busy long time
// - other instructions short busy, status read none
// - home zeroes counter, undoes shift, keeps RAM
// - entry mode bit picks counter step direction
// - glyph accesses step counter same direction
// - shift-enabled display writes shift whole display
// - display enable bit blanks panel, keeps RAM
// - cursor bit shows or hides cursor
// - blink alternates cursor cell with solid block
// - bit7 instruction loads display RAM address
// - status read gives busy and counter
// - data write stores into selected RAM
// - data read returns byte from selected RAM
// - table zero shift moves cursor or display
// - table zero code 01 loads glyph address
// - table one code 0100 loads icon address
// - table one stores icon, booster, upper contrast
// - table one stores follower, ratio, lower contrast
// - width bit picks 8-bit or nibble pairs
// - busy device refuses further instructions
// - display address ranges follow line mode
`ifndef CID_DEFINES_VH
`define CID_DEFINES_VH
`define CID_OFF_CMD 4'h0
`define CID_OFF_DATA 4'h4
`define CID_OFF_STATE 4'h8
`define CID_OFF_ANALOG 4'hC
`define CID_RAM_DISP 2'h0
`define CID_RAM_GLYPH 2'h1
`define CID_RAM_ICON 2'h2
`define CID_SPACE 8'h20
`define CID_L1_END 7'h27
`define CID_L2_START 7'h40
`define CID_L2_END 7'h67
`define CID_ONE_END 7'h4F
`define CID_SHIFT_MAX 6'h27
`define CID_CLK_NS 10
`define CID_LONG_NS_SLOW 1080000
`define CID_LONG_NS_540 760000
`define CID_LONG_NS_700 590000
`define CID_SHORT_NS_SLOW 26300
`define CID_SHORT_NS_540 18500
`define CID_SHORT_NS_700 14300
`define CID_CYC(ns) (((ns) + `CID_CLK_NS - 1) / `CID_CLK_NS)
`define CID_RST_BUS8 1'b1
`define CID_RST_INC 1'b1
`define CID_BLINK_CYCLES 25000000
`endif

// ---- verilog/cid_decoder.v ----
// instruction decoder and executor for a character display controller
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cid_defines.vh"
module cid_decoder #(
    parameter OSC_SEL = 0,
    parameter LONG_CYCLES = (OSC_SEL == 0) ? `CID_CYC(`CID_LONG_NS_SLOW) :
        (OSC_SEL == 1) ? `CID_CYC(`CID_LONG_NS_540) : `CID_CYC(`CID_LONG_NS_700),
    parameter SHORT_CYCLES = (OSC_SEL == 0) ? `CID_CYC(`CID_SHORT_NS_SLOW) :
        (OSC_SEL == 1) ? `CID_CYC(`CID_SHORT_NS_540) : `CID_CYC(`CID_SHORT_NS_700),
    parameter BLINK_CYCLES = `CID_BLINK_CYCLES,
    parameter CNT_W = 18,
    parameter BLK_W = 26
) (
    input wire CLK,
    input wire RESET_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output reg DISPLAY_ON,
    output reg CURSOR_ON,
    output reg CURSOR_SOLID,
    output reg [5:0] DISPLAY_SHIFT,
    output reg TWO_LINE,
    output reg TALL_FONT,
    output reg ICON_ON,
    output reg BOOSTER_ON,
    output reg FOLLOWER_ON,
    output reg BIAS_QUARTER,
    output reg [2:0] OSC_ADJUST,
    output reg [2:0] AMP_RATIO,
    output reg [5:0] CONTRAST
);

// cut the 32-bit counts to the counter widths on purpose
localparam [31:0] LONG_32 = LONG_CYCLES;
localparam [31:0] SHORT_32 = SHORT_CYCLES;
localparam [31:0] BLINK_M1 = BLINK_CYCLES - 1;
localparam [CNT_W-1:0] LONG_LD = LONG_32[CNT_W-1:0];
localparam [CNT_W-1:0] SHORT_LD = SHORT_32[CNT_W-1:0];
localparam [BLK_W-1:0] BLINK_LD = BLINK_M1[BLK_W-1:0];

reg [7:0] disp_mem [0:127];
reg [7:0] glyph_mem [0:63];
reg [7:0] icon_mem [0:15];

reg [6:0] address_counter;
reg [1:0] ram_sel;
reg entry_inc;
reg shift_en;
reg bus_width_select;
reg table_select;
reg blink_on;
reg nib_phase;
reg [3:0] nib_hi;
reg [CNT_W-1:0] busy_cnt;
reg fill_active;
reg [6:0] fill_idx;
reg [BLK_W-1:0] blink_cnt;
reg blink_phase;

// display address step with line wrap
function [6:0] disp_step;
    input [6:0] a;
    input inc;
    input two;
    begin
        if (two) begin
            if (inc)
                disp_step = (a == `CID_L1_END) ? `CID_L2_START :
                            (a == `CID_L2_END) ? 7'h00 : a + 7'h01;
            else
                disp_step = (a == `CID_L2_START) ? `CID_L1_END :
                            (a == 7'h00) ? `CID_L2_END : a - 7'h01;
        end else begin
            if (inc)
                disp_step = (a == `CID_ONE_END) ? 7'h00 : a + 7'h01;
            else
                disp_step = (a == 7'h00) ? `CID_ONE_END : a - 7'h01;
        end
    end
endfunction

// counter step for whichever RAM is selected
function [6:0] ac_step;
    input [6:0] a;
    input [1:0] sel;
    input inc;
    input two;
    reg [5:0] g;
    reg [3:0] c;
    begin
        g = inc ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
        c = inc ? a[3:0] + 4'h1 : a[3:0] - 4'h1;
        case (sel)
            `CID_RAM_GLYPH: ac_step = {1'b0, g};
            `CID_RAM_ICON: ac_step = {3'h0, c};
            default: ac_step = disp_step(a, inc, two);
        endcase
    end
endfunction

// shift offset kept modulo one line of forty cells
function [5:0] shift_step;
    input [5:0] s;
    input left;
    begin
        if (left)
            shift_step = (s == `CID_SHIFT_MAX) ? 6'h00 : s + 6'h01;
        else
            shift_step = (s == 6'h00) ? `CID_SHIFT_MAX : s - 6'h01;
    end
endfunction

wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
wire [3:0] adr = {WB_ADR_I[3:2], 2'b00};
wire wr = req & WB_WE_I & WB_SEL_I[0];
wire rd = req & ~WB_WE_I;
wire at_cmd = (adr == `CID_OFF_CMD);
wire at_data = (adr == `CID_OFF_DATA);
wire busy_flag = (busy_cnt != {CNT_W{1'b0}}) | fill_active;
// in nibble mode the second half of a pair completes the byte
wire byte_done = bus_width_select | nib_phase;
wire [7:0] in_byte = bus_width_select ? WB_DAT_I[7:0] : {nib_hi, WB_DAT_I[7:4]};
wire acc_wr = wr & (at_cmd | at_data) & ~busy_flag;
wire acc_rd_data = rd & at_data & ~busy_flag;
wire acc_rd_stat = rd & at_cmd;
wire cmd_go = acc_wr & at_cmd & byte_done;
wire data_go = acc_wr & at_data & byte_done;
wire data_rd_go = acc_rd_data & byte_done;

reg [7:0] ram_byte;
always @* begin
    case (ram_sel)
        `CID_RAM_GLYPH: ram_byte = glyph_mem[address_counter[5:0]];
        `CID_RAM_ICON: ram_byte = icon_mem[address_counter[3:0]];
        default: ram_byte = disp_mem[address_counter];
    endcase
end

// busy data reads return zero, not RAM; the status, state and analog words stay readable then
wire [7:0] data_byte = busy_flag ? 8'h00 : ram_byte;
wire [7:0] stat_byte = {busy_flag, address_counter};

function [7:0] nib_fmt;
    input [7:0] b;
    input eight;
    input second;
    begin
        nib_fmt = (eight | ~second) ? b : {b[3:0], 4'h0};
    end
endfunction

// memories carry no reset; clear fills the display RAM one cell per cycle
always @(posedge CLK) begin
    if (fill_active)
        disp_mem[fill_idx] <= `CID_SPACE;
    else if (data_go) begin
        case (ram_sel)
            `CID_RAM_GLYPH: glyph_mem[address_counter[5:0]] <= in_byte;
            `CID_RAM_ICON: icon_mem[address_counter[3:0]] <= in_byte;
            default: disp_mem[address_counter] <= in_byte;
        endcase
    end
end

always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 32'h00000000;
    end else begin
        WB_ACK_O <= req;
        if (rd) begin
            case (adr)
                `CID_OFF_CMD:
                    WB_DAT_O <= {24'h000000, nib_fmt(stat_byte, bus_width_select, nib_phase)};
                `CID_OFF_DATA:
                    WB_DAT_O <= {24'h000000, nib_fmt(data_byte, bus_width_select, nib_phase)};
                `CID_OFF_STATE:
                    WB_DAT_O <= {12'h000, DISPLAY_SHIFT, ram_sel, table_select, TALL_FONT,
                                 TWO_LINE, bus_width_select, shift_en, entry_inc,
                                 blink_on, CURSOR_ON, DISPLAY_ON, fill_active,
                                 busy_flag, nib_phase};
                `CID_OFF_ANALOG:
                    WB_DAT_O <= {16'h0000, CONTRAST, AMP_RATIO, OSC_ADJUST, FOLLOWER_ON,
                                 BOOSTER_ON, ICON_ON, BIAS_QUARTER};
                default:
                    WB_DAT_O <= 32'h00000000;
            endcase
        end else begin
            WB_DAT_O <= 32'h00000000;
        end
    end
end

// cursor blink timebase
always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
        blink_cnt <= {BLK_W{1'b0}};
        blink_phase <= 1'b0;
        CURSOR_SOLID <= 1'b0;
    end else begin
        if (blink_cnt == BLINK_LD) begin
            blink_cnt <= {BLK_W{1'b0}};
            blink_phase <= ~blink_phase;
        end else begin
            blink_cnt <= blink_cnt + {{(BLK_W-1){1'b0}}, 1'b1};
        end
        CURSOR_SOLID <= blink_on & DISPLAY_ON & blink_phase;
    end
end

always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
        address_counter <= 7'h00;
        ram_sel <= `CID_RAM_DISP;
        entry_inc <= `CID_RST_INC;
        shift_en <= 1'b0;
        bus_width_select <= `CID_RST_BUS8;
        table_select <= 1'b0;
        blink_on <= 1'b0;
        nib_phase <= 1'b0;
        nib_hi <= 4'h0;
        busy_cnt <= {CNT_W{1'b0}};
        fill_active <= 1'b0;
        fill_idx <= 7'h00;
        DISPLAY_ON <= 1'b0;
        CURSOR_ON <= 1'b0;
        DISPLAY_SHIFT <= 6'h00;
        TWO_LINE <= 1'b0;
        TALL_FONT <= 1'b0;
        ICON_ON <= 1'b0;
        BOOSTER_ON <= 1'b0;
        FOLLOWER_ON <= 1'b0;
        BIAS_QUARTER <= 1'b0;
        OSC_ADJUST <= 3'h0;
        AMP_RATIO <= 3'h0;
        CONTRAST <= 6'h00;
    end else begin
        if (busy_cnt != {CNT_W{1'b0}})
            busy_cnt <= busy_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        if (fill_active) begin
            fill_idx <= fill_idx + 7'h01;
            if (fill_idx == 7'h7F)
                fill_active <= 1'b0;
        end
        // nibble pairing: accepted accesses alternate halves
        if (!bus_width_select && (acc_wr || acc_rd_data || acc_rd_stat)) begin
            nib_phase <= ~nib_phase;
            if (!nib_phase)
                nib_hi <= WB_DAT_I[7:4];
        end
        if (data_go) begin
            busy_cnt <= SHORT_LD;
            address_counter <= ac_step(address_counter, ram_sel, entry_inc,
                                       TWO_LINE);
            if (shift_en && ram_sel == `CID_RAM_DISP)
                DISPLAY_SHIFT <= shift_step(DISPLAY_SHIFT, entry_inc);
        end
        if (data_rd_go) begin
            busy_cnt <= SHORT_LD;
            address_counter <= ac_step(address_counter, ram_sel, entry_inc,
                                       TWO_LINE);
        end
        if (cmd_go) begin
            busy_cnt <= SHORT_LD;
            casez (in_byte)
                8'b1???????: begin
                    address_counter <= in_byte[6:0];
                    ram_sel <= `CID_RAM_DISP;
                end
                8'b01??????: begin
                    if (!table_select) begin
                        address_counter <= {1'b0, in_byte[5:0]};
                        ram_sel <= `CID_RAM_GLYPH;
                    end else begin
                        case (in_byte[5:4])
                            2'b00: begin
                                address_counter <= {3'h0, in_byte[3:0]};
                                ram_sel <= `CID_RAM_ICON;
                            end
                            2'b01: begin
                                ICON_ON <= in_byte[3];
                                BOOSTER_ON <= in_byte[2];
                                CONTRAST[5:4] <= in_byte[1:0];
                            end
                            2'b10: begin
                                FOLLOWER_ON <= in_byte[3];
                                AMP_RATIO <= in_byte[2:0];
                            end
                            default: CONTRAST[3:0] <= in_byte[3:0];
                        endcase
                    end
                end
                8'b001?????: begin
                    // the test bit is left to the host and not decoded
                    bus_width_select <= in_byte[4];
                    TWO_LINE <= in_byte[3];
                    TALL_FONT <= in_byte[2];
                    table_select <= in_byte[0];
                    nib_phase <= 1'b0;
                end
                8'b0001????: begin
                    if (table_select) begin
                        BIAS_QUARTER <= in_byte[3];
                        OSC_ADJUST <= in_byte[2:0];
                    end else if (in_byte[3]) begin
                        DISPLAY_SHIFT <= shift_step(DISPLAY_SHIFT, ~in_byte[2]);
                    end else begin
                        address_counter <= disp_step(address_counter, in_byte[2],
                                                     TWO_LINE);
                    end
                end
                8'b00001???: begin
                    DISPLAY_ON <= in_byte[2];
                    CURSOR_ON <= in_byte[1];
                    blink_on <= in_byte[0];
                end
                8'b000001??: begin
                    entry_inc <= in_byte[1];
                    shift_en <= in_byte[0];
                end
                8'b0000001?: begin
                    busy_cnt <= LONG_LD;
                    address_counter <= 7'h00;
                    ram_sel <= `CID_RAM_DISP;
                    DISPLAY_SHIFT <= 6'h00;
                end
                8'b00000001: begin
                    busy_cnt <= LONG_LD;
                    address_counter <= 7'h00;
                    ram_sel <= `CID_RAM_DISP;
                    entry_inc <= 1'b1;
                    DISPLAY_SHIFT <= 6'h00;
                    fill_active <= 1'b1;
                    fill_idx <= 7'h00;
                end
                default: begin
                end
            endcase
        end
    end
end

endmodule

// ---- test/cid_checker_assertions.sv ----
// bus and output checks on the instruction decoder's ports
`timescale 1ns/1ps
module cid_checker (
    input wire CLK,
    input wire RESET_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire DISPLAY_ON,
    input wire CURSOR_ON,
    input wire CURSOR_SOLID,
    input wire [5:0] DISPLAY_SHIFT,
    input wire TWO_LINE,
    input wire TALL_FONT,
    input wire ICON_ON,
    input wire BOOSTER_ON,
    input wire FOLLOWER_ON,
    input wire BIAS_QUARTER,
    input wire [2:0] OSC_ADJUST,
    input wire [2:0] AMP_RATIO,
    input wire [5:0] CONTRAST
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered on the next edge");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge held longer than one cycle");
    a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data driven outside a read answer");
    a_write_dat: assert property (WB_ACK_O && $past(WB_WE_I) |-> WB_DAT_O == 32'h0)
        else $error("read data driven on a write answer");
    a_shift_range: assert property (DISPLAY_SHIFT <= 6'h27)
        else $error("display shift beyond forty positions");
    a_shift_step: assert property ($changed(DISPLAY_SHIFT) |-> DISPLAY_SHIFT == 6'h0
        || DISPLAY_SHIFT == $past(DISPLAY_SHIFT) + 6'h1
        || DISPLAY_SHIFT == $past(DISPLAY_SHIFT) - 6'h1
        || ($past(DISPLAY_SHIFT) == 6'h0 && DISPLAY_SHIFT == 6'h27))
        else $error("display shift moved by more than one");
    a_shift_cause: assert property ($changed(DISPLAY_SHIFT) |-> WB_ACK_O && $past(WB_WE_I))
        else $error("display shift changed without a write");
    a_analog_cause: assert property (
        $changed({ICON_ON, BOOSTER_ON, FOLLOWER_ON, BIAS_QUARTER, OSC_ADJUST, AMP_RATIO, CONTRAST})
        |-> WB_ACK_O && $past(WB_WE_I) && $past(WB_ADR_I[3:2]) == 2'h0)
        else $error("analog setting changed without an instruction");
    a_ctrl_cause: assert property (
        $changed({DISPLAY_ON, CURSOR_ON, TWO_LINE, TALL_FONT})
        |-> WB_ACK_O && $past(WB_WE_I) && $past(WB_ADR_I[3:2]) == 2'h0)
        else $error("display control changed without an instruction");
    a_blank_solid: assert property (!DISPLAY_ON && !$past(DISPLAY_ON) |-> !CURSOR_SOLID)
        else $error("blink block shown on a blanked panel");
endmodule

bind cid_decoder cid_checker i_cid_checker (.CLK(CLK), .RESET_N(RESET_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .DISPLAY_ON(DISPLAY_ON),
    .CURSOR_ON(CURSOR_ON), .CURSOR_SOLID(CURSOR_SOLID), .DISPLAY_SHIFT(DISPLAY_SHIFT),
    .TWO_LINE(TWO_LINE), .TALL_FONT(TALL_FONT), .ICON_ON(ICON_ON),
    .BOOSTER_ON(BOOSTER_ON), .FOLLOWER_ON(FOLLOWER_ON), .BIAS_QUARTER(BIAS_QUARTER),
    .OSC_ADJUST(OSC_ADJUST), .AMP_RATIO(AMP_RATIO), .CONTRAST(CONTRAST));

// ---- test/cid_host.sv ----
// host processor model issuing classic bus cycles to the decoder
`timescale 1ns/1ps
module cid_host (
    input wire clk,
    input wire ack,
    input wire [31:0] din,
    output reg cyc = 1'b0,
    output reg stb = 1'b0,
    output reg we = 1'b0,
    output reg [3:0] adr = 4'h0,
    output reg [31:0] dout = 32'h0
);
    task xfer(input w, input [3:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dout <= d;
            @(posedge clk);
            while (ack !== 1'b1)
                @(posedge clk);
            q = din;
            cyc <= 1'b0;
            stb <= 1'b0;
            // released lines must not keep showing the last value
            we <= ~w;
            adr <= ~a;
            dout <= ~d;
        end
    endtask
endmodule

// ---- test/test_cid_decoder.sv ----
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module test_cid_decoder;
    localparam SHORT = 20;
    localparam LONG = 300;
    reg CLK = 1'b0;
    reg RESET_N = 1'b0;
    wire cyc, stb, we, ack, d_on, c_on, solid, two, tall, icon, boost, fol, bias;
    wire [3:0] adr;
    wire [31:0] wdat, rdat;
    wire [5:0] shf, ctr;
    wire [2:0] osc, amp;
    reg [31:0] rd_q, st;
    integer num_errors = 0, check_count = 0, cycles = 0, n, t0;
    cid_decoder #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT), .BLINK_CYCLES(8)) i_cid_decoder (
        .CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .DISPLAY_ON(d_on), .CURSOR_ON(c_on), .CURSOR_SOLID(solid), .DISPLAY_SHIFT(shf),
        .TWO_LINE(two), .TALL_FONT(tall), .ICON_ON(icon), .BOOSTER_ON(boost),
        .FOLLOWER_ON(fol), .BIAS_QUARTER(bias), .OSC_ADJUST(osc), .AMP_RATIO(amp),
        .CONTRAST(ctr));
    cid_host host (.clk(CLK), .ack(ack), .din(rdat), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .dout(wdat));
    always #5 CLK = ~CLK;
    task close_out;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            close_out;
        end
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0s expected %0h seen %0h", nm, e, g);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, st);
    endtask
    task rd(input [3:0] a);
        host.xfer(1'b0, a, 32'h0, rd_q);
    endtask
    // polls the state view so that nibble pairing is not disturbed
    task idle;
        begin
            n = 0;
            host.xfer(1'b0, 4'h8, 32'h0, st);
            while (st[1] !== 1'b0 && n < 400) begin
                host.xfer(1'b0, 4'h8, 32'h0, st);
                n = n + 1;
            end
            chk("idle", 32'h0, {31'h0, st[1]});
        end
    endtask
    task cmd(input [7:0] d);
        begin
            wr(4'h0, d);
            idle;
        end
    endtask
    task dat(input [7:0] d);
        begin
            wr(4'h4, d);
            idle;
        end
    endtask
    task rdd(input [7:0] e);
        begin
            rd(4'h4);
            chk("ram", {24'h0, e}, rd_q);
            idle;
        end
    endtask
    task timed(input [7:0] d, input integer len);
        begin
            wr(4'h0, d);
            t0 = cycles;
            idle;
            chk("busy time", 32'h1, {31'h0, cycles - t0 >= len - 2 && cycles - t0 <= len + 6});
        end
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(4'h0);
        chk("status", 32'h0, rd_q);
        wr(4'h0, 8'h38);
        wr(4'h0, 8'h0F);
        rd(4'h0);
        chk("busy", 32'h80, rd_q);
        idle;
        chk("refused", 32'h0, {31'h0, d_on});
        timed(8'h06, SHORT);
        timed(8'h01, LONG);
        rd(4'h0);
        chk("clear", 32'h0, rd_q);
        cmd(8'h0F);
        chk("disp", 32'h1, {31'h0, d_on});
        chk("cursor", 32'h1, {31'h0, c_on});
        n = 0;
        while (solid !== 1'b1 && n < 40) begin
            @(posedge CLK);
            n = n + 1;
        end
        chk("blink", 32'h1, {31'h0, solid});
        cmd(8'h0C);
        repeat (3) @(posedge CLK);
        chk("blink off", 32'h0, {31'h0, solid});
        chk("cursor", 32'h0, {31'h0, c_on});
        rd(4'h8);
        chk("inc", 32'h1, {31'h0, rd_q[6]});
        cmd(8'hC0);
        dat(8'h41);
        dat(8'h42);
        rd(4'h0);
        chk("counter", 32'h42, rd_q);
        cmd(8'hA7);
        dat(8'h43);
        rd(4'h0);
        chk("wrap", 32'h40, rd_q);
        cmd(8'hC0);
        rdd(8'h41);
        cmd(8'h07);
        cmd(8'h80);
        dat(8'h44);
        chk("shift", 32'h1, {26'h0, shf});
        rdd(8'h20);
        chk("shift", 32'h1, {26'h0, shf});
        cmd(8'h05);
        dat(8'h45);
        chk("shift", 32'h0, {26'h0, shf});
        rd(4'h0);
        chk("counter", 32'h1, rd_q);
        cmd(8'h1C);
        chk("shift", 32'h27, {26'h0, shf});
        cmd(8'h14);
        rd(4'h0);
        chk("counter", 32'h2, rd_q);
        cmd(8'h02);
        chk("shift", 32'h0, {26'h0, shf});
        rdd(8'h44);
        cmd(8'h06);
        cmd(8'h48);
        rd(4'h0);
        chk("glyph", 32'h8, rd_q);
        dat(8'h1F);
        rd(4'h0);
        chk("glyph", 32'h9, rd_q);
        cmd(8'h48);
        rdd(8'h1F);
        cmd(8'h39);
        cmd(8'h1D);
        chk("osc", 32'hD, {28'h0, bias, osc});
        cmd(8'h5E);
        cmd(8'h6D);
        cmd(8'h7A);
        chk("analog", 32'hF6A, {20'h0, icon, boost, fol, amp, ctr});
        cmd(8'h43);
        dat(8'h15);
        cmd(8'h43);
        rdd(8'h15);
        cmd(8'h38);
        cmd(8'h08);
        chk("disp", 32'h0, {31'h0, d_on});
        cmd(8'h28);
        wr(4'h0, 8'h00);
        cmd(8'hC0);
        chk("nibble", 32'h1, {31'h0, d_on});
        rd(4'h0);
        chk("nibble", 32'h4, rd_q);
        rd(4'h0);
        chk("nibble", 32'h40, rd_q);
        wr(4'h0, 8'h30);
        cmd(8'h40);
        rd(4'h8);
        chk("width", 32'h1, {31'h0, rd_q[8]});
        chk("lines", 32'h1, {30'h0, two, tall});
        close_out;
    end
endmodule
